// ### tm_packetizer.sv
// Timing data packet generator: builds the timing structure, splits it
// into RTP/UDP/IPv4 packets and streams them as bytes to the link mux.
// Assumes an AXI4-Lite master for configuration and a byte sink that
// may stall with tunReady.
// Functional notes
// - Flag sets not finished within one frame
// - Destination 239.0.51.48, port 30065 plus offset
// - Split structure; each packet fits MTU
// - Payloads are consecutive fragments; structure carries CRC16
// - Marker set only on structure-start packet
// - One timestamp for whole packet set
// - Timestamp from first emission seconds and nanoseconds
// - Padding bit always zero
// - Extension bit zero; no extension produced
// - Contributing-source count zero, no list
// - Payload type 76
// - Sequence number increments per packet
// - Synchronization source identifier zero
// - Structure begins length, versions, counts, gap code
// - Packets go to link only, never radiated
// - Single marked packet when MTU allows; code splits at the REG_SEG fragment size if it is smaller
// - Timestamp top 22 bits from seconds LSBs
// - Timestamp low 10 bits from nanoseconds
// - Major and minor versions emitted zero
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
module tm_packetizer
   import tm_pkt_pkg::*;
#(
   parameter int BUF_WORDS = 16,
   parameter int MTU_BYTES = 1500,
   parameter int FRAME_TIME_US = 100000,
   parameter int FRAME_CYC = FRAME_TIME_US * 1000 / CLK_PERIOD_NS
)
(
   input wire logic sys_clk, // System clock
   input wire logic reset, // Asynchronous reset
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic [7:0] tunData, // Packet byte
   output logic tunValid, // Byte valid
   input wire logic tunReady, // Sink takes byte
   output logic tunFirst, // First byte of packet
   output logic tunLast // Last byte of packet
);
   localparam int IDX_W = $clog2(BUF_WORDS);
   localparam logic [15:0] FRAG_CAP = 16'(MTU_BYTES - 40);

   // ==========================================================
   // Register bus
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [7:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic bValid_q, bValid_d, rValid_q, rValid_d;
   logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
   logic [31:0] rData_q, rData_d;
   logic [31:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d, sec_q, sec_d, ns_q, ns_d;
   logic [31:0] srcIp_q, srcIp_d, net_q, net_d, seg_q, seg_d;
   logic [31:0] buf_q [BUF_WORDS];
   logic [31:0] buf_d [BUF_WORDS];
   logic startReq, lateClr;
   gen_state_t state_q, state_d;
   logic late_q, late_d;
   logic [15:0] seq_q, seq_d;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (d & m);
   endfunction

   function automatic logic isBufAddr(input logic [7:0] a);
      logic [7:0] off;
      off = a - REG_BUF;
      return (a >= REG_BUF) && ({2'b00, off[7:2]} < 8'(BUF_WORDS));
   endfunction

   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rresp = rResp_q;
   assign s_axi_rdata = rData_q;

   always_comb
   begin
      logic doWrite;
      logic [7:0] off;
      doWrite = awHeld_q && wHeld_q && !bValid_q;
      off = 8'h00;
      awHeld_d = awHeld_q;
      awAddr_d = awAddr_q;
      wHeld_d = wHeld_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bValid_d = bValid_q && !s_axi_bready;
      bResp_d = bResp_q;
      rValid_d = rValid_q && !s_axi_rready;
      rResp_d = rResp_q;
      rData_d = rData_q;
      cfg0_d = cfg0_q;
      cfg1_d = cfg1_q;
      sec_d = sec_q;
      ns_d = ns_q;
      srcIp_d = srcIp_q;
      net_d = net_q;
      seg_d = seg_q;
      buf_d = buf_q;
      startReq = 1'b0;
      lateClr = 1'b0;
      if (s_axi_awvalid && !awHeld_q)
      begin
         awHeld_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q)
      begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      if (doWrite)
      begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bValid_d = 1'b1;
         bResp_d = 2'b00;
         off = awAddr_q - REG_BUF;
         case (awAddr_q)
            REG_CTRL:
            begin
               startReq = wStrb_q[0] && wData_q[0] && (state_q == ST_IDLE);
               lateClr = wStrb_q[0] && wData_q[1];
            end
            REG_CFG0: cfg0_d = merge(cfg0_q, wData_q, wStrb_q);
            REG_CFG1: cfg1_d = merge(cfg1_q, wData_q, wStrb_q);
            REG_SEC: sec_d = merge(sec_q, wData_q, wStrb_q);
            REG_NS: ns_d = merge(ns_q, wData_q, wStrb_q);
            REG_SRCIP: srcIp_d = merge(srcIp_q, wData_q, wStrb_q);
            REG_NET: net_d = merge(net_q, wData_q, wStrb_q);
            REG_SEG: seg_d = merge(seg_q, wData_q, wStrb_q);
            REG_STAT: bResp_d = 2'b00;
            default:
               if (isBufAddr(awAddr_q))
                  buf_d[off[IDX_W+1:2]] = merge(buf_q[off[IDX_W+1:2]],
                     wData_q, wStrb_q);
               else
                  bResp_d = 2'b10;
         endcase
      end
      if (s_axi_arvalid && !rValid_q)
      begin
         rValid_d = 1'b1;
         rResp_d = 2'b00;
         off = s_axi_araddr - REG_BUF;
         case (s_axi_araddr)
            REG_CTRL: rData_d = 32'h00000000;
            REG_CFG0: rData_d = cfg0_q;
            REG_CFG1: rData_d = cfg1_q;
            REG_SEC: rData_d = sec_q;
            REG_NS: rData_d = ns_q;
            REG_SRCIP: rData_d = srcIp_q;
            REG_NET: rData_d = net_q;
            REG_SEG: rData_d = seg_q;
            REG_STAT: rData_d = {seq_q, 14'h0000, late_q,
               state_q == ST_SEND};
            default:
               if (isBufAddr(s_axi_araddr))
                  rData_d = buf_q[off[IDX_W+1:2]];
               else
               begin
                  rData_d = 32'h00000000;
                  rResp_d = 2'b10;
               end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         awHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wHeld_q <= 1'b0;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= 2'b00;
         rValid_q <= 1'b0;
         rResp_q <= 2'b00;
         rData_q <= 32'h00000000;
         cfg0_q <= RST_CFG0;
         cfg1_q <= RST_CFG1;
         sec_q <= 32'h00000000;
         ns_q <= 32'h00000000;
         srcIp_q <= RST_SRCIP;
         net_q <= RST_NET;
         seg_q <= RST_SEG;
         buf_q <= '{default: 32'h00000000};
      end
      else
      begin
         awHeld_q <= awHeld_d;
         awAddr_q <= awAddr_d;
         wHeld_q <= wHeld_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
         rValid_q <= rValid_d;
         rResp_q <= rResp_d;
         rData_q <= rData_d;
         cfg0_q <= cfg0_d;
         cfg1_q <= cfg1_d;
         sec_q <= sec_d;
         ns_q <= ns_d;
         srcIp_q <= srcIp_d;
         net_q <= net_d;
         seg_q <= seg_d;
         buf_q <= buf_d;
      end
   end

   // ==========================================================
   // Packet generator
   logic [159:0] hdr_q, hdr_d;
   logic [15:0] total_q, total_d, frag_q, frag_d;
   logic [15:0] sPos_q, sPos_d, pktStart_q, pktStart_d;
   logic [15:0] bPos_q, bPos_d, payLen_q, payLen_d;
   logic [15:0] crc_q, crc_d;
   logic [31:0] budget_q, budget_d;
   logic [7:0] outData_q, outData_d;
   logic outValid_q, outValid_d, outFirst_q, outFirst_d;
   logic outLast_q, outLast_d;
   logic [15:0] outPos_q, outPos_d;
   logic [319:0] pktHdr;
   logic [31:0] tsVal;
   logic [15:0] ipLen, dstPort;
   logic [7:0] curByte;
   logic advance, lastByte, pktDone;
   calc_if calc ();

   crc16_byte uCrc (
      .calc(calc)
   );

   ip_checksum uSum (
      .calc(calc)
   );

   assign tsVal = {hdr_q[53:32], hdr_q[29:20]};
   assign dstPort = DST_PORT + {8'h00, net_q[23:16]};
   assign ipLen = ALL_HDR_BYTES + payLen_q;
   assign calc.ipLen = ipLen;
   assign calc.ipId = seq_q;
   assign calc.ttl = net_q[31:24];
   assign calc.srcIp = srcIp_q;
   assign calc.dstIp = DST_IP;
   assign calc.crcIn = crc_q;
   assign calc.crcByte = curByte;

   assign pktHdr = {8'h45, 8'h00, ipLen, seq_q, 16'h0000, net_q[31:24],
      IP_PROTO_UDP, calc.ipSum, srcIp_q, DST_IP, net_q[15:0], dstPort,
      ipLen - IP_HDR_BYTES, 16'h0000, RTP_VER, 1'b0, 1'b0, 4'h0,
      pktStart_q == 16'h0000, RTP_PT, seq_q, tsVal, 32'h00000000};

   assign advance = (state_q == ST_SEND) && (!outValid_q || tunReady);
   assign lastByte = bPos_q == ALL_HDR_BYTES + payLen_q - 16'h0001;
   assign pktDone = advance && lastByte;

   always_comb
   begin
      logic [15:0] bi;
      bi = sPos_q - STRUCT_FIX_BYTES;
      if (bPos_q < ALL_HDR_BYTES)
         curByte = pktHdr[319 - 8 * int'(bPos_q[5:0]) -: 8];
      else if (sPos_q < STRUCT_FIX_BYTES)
         curByte = hdr_q[159 - 8 * int'(sPos_q[4:0]) -: 8];
      else if (sPos_q < total_q - CRC_BYTES)
         curByte = buf_q[bi[IDX_W+1:2]][31 - 8 * int'(bi[1:0]) -: 8];
      else if (sPos_q == total_q - CRC_BYTES)
         curByte = crc_q[15:8];
      else
         curByte = crc_q[7:0];
   end

   always_comb
   begin
      logic [15:0] extra, rem, fragReq;
      extra = {8'h00, seg_q[23:16]};
      if (extra > 16'(BUF_WORDS * 4))
         extra = 16'(BUF_WORDS * 4);
      fragReq = seg_q[15:0];
      rem = total_q - sPos_q - 16'h0001;
      state_d = state_q;
      hdr_d = hdr_q;
      total_d = total_q;
      frag_d = frag_q;
      sPos_d = sPos_q;
      pktStart_d = pktStart_q;
      bPos_d = bPos_q;
      payLen_d = payLen_q;
      crc_d = crc_q;
      seq_d = seq_q;
      budget_d = budget_q;
      late_d = late_q && !lateClr;
      outData_d = outData_q;
      outValid_d = outValid_q && !tunReady;
      outFirst_d = outFirst_q;
      outLast_d = outLast_q;
      outPos_d = outPos_q;
      case (state_q)
         ST_IDLE:
            if (startReq)
            begin
               state_d = ST_SEND;
               total_d = STRUCT_FIX_BYTES + extra + CRC_BYTES;
               hdr_d = {total_d, 4'h0, 4'h0, cfg0_q[3:0], cfg0_q[7:4],
                  cfg0_q[11:8], cfg0_q[15:12], cfg0_q[20:16],
                  cfg0_q[22:21], cfg0_q[29:23], cfg1_q[7:0], cfg1_q[9:8],
                  6'h00, cfg1_q[15:10], cfg1_q[22:16], cfg1_q[25:23],
                  cfg1_q[27:26], cfg1_q[29:28], 6'h3f, sec_q, ns_q};
               frag_d = (fragReq == 16'h0000 || fragReq > FRAG_CAP)
                  ? FRAG_CAP : fragReq;
               payLen_d = (total_d < frag_d) ? total_d : frag_d;
               sPos_d = 16'h0000;
               pktStart_d = 16'h0000;
               bPos_d = 16'h0000;
               crc_d = CRC_INIT;
               budget_d = 32'h00000000;
            end
         ST_SEND:
         begin
            budget_d = budget_q + 32'h00000001;
            if (budget_q == 32'(FRAME_CYC - 1))
               late_d = 1'b1;
            if (advance)
            begin
               // Bytes go only to the link stream
               outData_d = curByte;
               outValid_d = 1'b1;
               outFirst_d = bPos_q == 16'h0000;
               outLast_d = lastByte;
               outPos_d = bPos_q;
               bPos_d = bPos_q + 16'h0001;
               if (bPos_q >= ALL_HDR_BYTES)
               begin
                  sPos_d = sPos_q + 16'h0001;
                  if (sPos_q < total_q - CRC_BYTES)
                     crc_d = calc.crcOut;
               end
               if (lastByte)
               begin
                  seq_d = seq_q + 16'h0001;
                  bPos_d = 16'h0000;
                  pktStart_d = sPos_d;
                  payLen_d = (rem < frag_q) ? rem : frag_q;
                  if (sPos_d == total_q)
                     state_d = ST_IDLE;
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         hdr_q <= '0;
         total_q <= 16'h0000;
         frag_q <= 16'h0000;
         sPos_q <= 16'h0000;
         pktStart_q <= 16'h0000;
         bPos_q <= 16'h0000;
         payLen_q <= 16'h0000;
         crc_q <= CRC_INIT;
         seq_q <= 16'h0000;
         budget_q <= 32'h00000000;
         late_q <= 1'b0;
         outData_q <= 8'h00;
         outValid_q <= 1'b0;
         outFirst_q <= 1'b0;
         outLast_q <= 1'b0;
         outPos_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         hdr_q <= hdr_d;
         total_q <= total_d;
         frag_q <= frag_d;
         sPos_q <= sPos_d;
         pktStart_q <= pktStart_d;
         bPos_q <= bPos_d;
         payLen_q <= payLen_d;
         crc_q <= crc_d;
         seq_q <= seq_d;
         budget_q <= budget_d;
         late_q <= late_d;
         outData_q <= outData_d;
         outValid_q <= outValid_d;
         outFirst_q <= outFirst_d;
         outLast_q <= outLast_d;
         outPos_q <= outPos_d;
      end
   end

   assign tunData = outData_q;
   assign tunValid = outValid_q;
   assign tunFirst = outFirst_q;
   assign tunLast = outLast_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_dstIp;
      outValid_q && outPos_q == POS_DST_IP |-> outData_q == DST_IP[31:24];
   endproperty
   a_dstIp: assert property (p_dstIp) else $error("bad dest ip");
   property p_dstPort;
      outValid_q && outPos_q == POS_DST_PORT |-> outData_q == dstPort[15:8];
   endproperty
   a_dstPort: assert property (p_dstPort) else $error("bad port");
   property p_fit;
      outValid_q && outLast_q |-> outPos_q < 16'(MTU_BYTES);
   endproperty
   a_fit: assert property (p_fit) else $error("packet over mtu");
   property p_marker;
      outValid_q && outPos_q == POS_RTP + 16'h0001
         |-> outData_q == {pktStart_q == 16'h0000, RTP_PT};
   endproperty
   a_marker: assert property (p_marker) else $error("bad marker");
   property p_tsStable;
      state_q == ST_SEND && $past(state_q) == ST_SEND |-> $stable(tsVal);
   endproperty
   a_tsStable: assert property (p_tsStable) else $error("ts moved");
   property p_ts;
      outValid_q && outPos_q == POS_TS |-> outData_q == hdr_q[53:46];
   endproperty
   a_ts: assert property (p_ts) else $error("bad timestamp");
   property p_rtpByte0;
      outValid_q && outPos_q == POS_RTP |-> outData_q == 8'h80;
   endproperty
   a_rtpByte0: assert property (p_rtpByte0) else $error("p x cc");
   property p_ssrc;
      outValid_q && outPos_q >= POS_SSRC && outPos_q < ALL_HDR_BYTES
         |-> outData_q == 8'h00;
   endproperty
   a_ssrc: assert property (p_ssrc) else $error("ssrc not zero");
   property p_seqStep;
      pktDone |=> seq_q == $past(seq_q) + 16'h0001;
   endproperty
   a_seqStep: assert property (p_seqStep) else $error("seq step");
   property p_ver;
      outValid_q && outPos_q == POS_VER && pktStart_q == 16'h0000
         |-> outData_q == 8'h00;
   endproperty
   a_ver: assert property (p_ver) else $error("version not 0");
   property p_late;
      state_q == ST_SEND && budget_q == 32'(FRAME_CYC - 1) |=> late_q;
   endproperty
   a_late: assert property (p_late) else $error("late not set");

   c_first: cover property (pktDone && pktStart_q == 16'h0000);
   c_cont: cover property (pktDone && pktStart_q != 16'h0000);
   c_stall: cover property (outValid_q && !tunReady);
   c_late: cover property (late_q);
endmodule // tm_packetizer

// ### tm_pkt_pkg.sv
// Constants, register map and types of the timing packet generator.
// Assumes a 10 MHz system clock and one 32-bit register word per offset.
package tm_pkt_pkg;
   // ==========================================================
   // Clock
   localparam int CLK_PERIOD_NS = 100;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CFG0 = 8'h04;
   localparam logic [7:0] REG_CFG1 = 8'h08;
   localparam logic [7:0] REG_SEC = 8'h0c;
   localparam logic [7:0] REG_NS = 8'h10;
   localparam logic [7:0] REG_SRCIP = 8'h14;
   localparam logic [7:0] REG_NET = 8'h18;
   localparam logic [7:0] REG_SEG = 8'h1c;
   localparam logic [7:0] REG_STAT = 8'h20;
   localparam logic [7:0] REG_BUF = 8'h40;

   // ==========================================================
   // Values after reset
   localparam logic [31:0] RST_CFG0 = 32'h00000011;
   localparam logic [31:0] RST_CFG1 = 32'h00000000;
   localparam logic [31:0] RST_SRCIP = 32'h00000000;
   localparam logic [31:0] RST_NET = 32'h40007571;
   localparam logic [31:0] RST_SEG = 32'h000005b4;

   // ==========================================================
   // Packet layout
   localparam logic [31:0] DST_IP = 32'hef003330;
   localparam logic [15:0] DST_PORT = 16'h7571;
   localparam logic [1:0] RTP_VER = 2'h2;
   localparam logic [6:0] RTP_PT = 7'h4c;
   localparam logic [7:0] IP_PROTO_UDP = 8'h11;
   localparam logic [15:0] IP_HDR_BYTES = 16'h0014;
   localparam logic [15:0] ALL_HDR_BYTES = 16'h0028;
   localparam logic [15:0] POS_DST_IP = 16'h0010;
   localparam logic [15:0] POS_DST_PORT = 16'h0016;
   localparam logic [15:0] POS_RTP = 16'h001c;
   localparam logic [15:0] POS_TS = 16'h0020;
   localparam logic [15:0] POS_SSRC = 16'h0024;
   localparam logic [15:0] POS_VER = 16'h002a;
   localparam logic [15:0] STRUCT_FIX_BYTES = 16'h0014;
   localparam logic [15:0] CRC_BYTES = 16'h0002;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;

   // ==========================================================
   // Generator states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } gen_state_t;
endpackage

// ### calc_if.sv
// Links the packet generator to its CRC and header checksum units.
// Assumes both units are purely combinational.
interface calc_if;
   logic [15:0] crcIn;
   logic [7:0] crcByte;
   logic [15:0] crcOut;
   logic [15:0] ipLen;
   logic [15:0] ipId;
   logic [7:0] ttl;
   logic [31:0] srcIp;
   logic [31:0] dstIp;
   logic [15:0] ipSum;
   modport crcUnit (input crcIn, input crcByte, output crcOut);
   modport sumUnit (input ipLen, input ipId, input ttl, input srcIp,
                    input dstIp, output ipSum);
   modport owner (output crcIn, output crcByte, output ipLen, output ipId,
                  output ttl, output srcIp, output dstIp,
                  input crcOut, input ipSum);
endinterface

// ### crc16_byte.sv
// One byte step of the structure CRC, most significant bit first.
// Assumes the caller holds the running value between bytes.
module crc16_byte
   import tm_pkt_pkg::*;
#(
   parameter logic [15:0] POLY = CRC_POLY
)
(
   calc_if.crcUnit calc // CRC operands
);
   always_comb
   begin
      logic [15:0] c;
      logic fb;
      c = calc.crcIn;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         fb = c[15] ^ calc.crcByte[i];
         c = {c[14:0], 1'b0};
         if (fb)
            c = c ^ POLY;
      end
      calc.crcOut = c;
   end
endmodule // crc16_byte

// ### ip_checksum.sv
// IPv4 header checksum for the fixed 20-byte header without options.
// Assumes flags and fragment offset zero and service byte zero.
module ip_checksum
   import tm_pkt_pkg::*;
(
   calc_if.sumUnit calc // Header fields and checksum
);
   always_comb
   begin
      logic [19:0] s;
      logic [16:0] f;
      logic [16:0] g;
      s = 20'h04500 + {4'h0, calc.ipLen} + {4'h0, calc.ipId}
         + {4'h0, calc.ttl, IP_PROTO_UDP}
         + {4'h0, calc.srcIp[31:16]} + {4'h0, calc.srcIp[15:0]}
         + {4'h0, calc.dstIp[31:16]} + {4'h0, calc.dstIp[15:0]};
      f = {1'b0, s[15:0]} + {13'h0000, s[19:16]};
      g = {1'b0, f[15:0]} + {16'h0000, f[16]};
      calc.ipSum = ~g[15:0];
   end
endmodule // ip_checksum

// ### tm_sink.sv
// Far-side byte sink of the link stream, stalling at random; rebuilds
// each structure from its packets and checks its length and CRC.
// Assumes the generator holds each byte until it is taken.
module tm_sink
   import tm_pkt_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic reset, // Reset, async for tunReady, sync for sets
   input wire logic [7:0] tunData, // Packet byte
   input wire logic tunValid, // Byte valid
   input wire logic tunFirst, // First byte of packet
   output logic tunReady, // Sink ready
   output int sets // Structures rebuilt intact
);
   timeunit 1ns;
   timeprecision 1ns;
   int seed = 98414;
   int pos = 0;
   int got = 0;
   logic mark = 1'b0;
   logic keep = 1'b0;
   logic [15:0] len = 16'h0000;
   logic [15:0] crc = 16'h0000;
   logic [15:0] rx = 16'h0000;
   logic [15:0] nextSeq = 16'h0000;

   function automatic logic [15:0] crcStep(input logic [15:0] c,
      input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction

   // Ready three cycles in four
   always @(posedge sys_clk or posedge reset)
      if (reset)
         tunReady <= 1'b0;
      else
         tunReady <= ($random(seed) & 3) != 0;

   // Rebuild from marker packet, drop set on gap
   always @(posedge sys_clk)
      if (reset)
         sets <= 0;
      else if (tunValid && tunReady)
      begin
         pos = tunFirst ? 0 : pos + 1;
         if (pos == 29)
            mark = tunData[7];
         if (pos == 30 || pos == 31 || pos >= 40)
            rx = {rx[7:0], tunData};
         if (pos == 31)
         begin
            if (mark)
            begin
               keep = 1'b1;
               got = 0;
               crc = CRC_INIT;
            end
            else if (rx != nextSeq)
               keep = 1'b0;
            nextSeq = rx + 16'h0001;
         end
         if (pos >= 40 && keep)
         begin
            if (got == 1)
               len = rx;
            if (got < 2 || got < int'(len) - 2)
               crc = crcStep(crc, tunData);
            if (got > 1 && got == int'(len) - 1)
            begin
               if (rx == crc)
                  sets <= sets + 1;
               keep = 1'b0;
            end
            got++;
         end
      end
endmodule // tm_sink

// ### timing_mgmt_rtp_packetizer_tb.sv
// Self-checking bench of the timing packet generator.
// Assumes AXI4-Lite configuration and a stalling byte sink.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t %h %h", $time, a, b); end end
module timing_mgmt_rtp_packetizer_tb;
   import tm_pkt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, reset = 1, awValid = 0, wValid = 0, bReady = 0;
   logic arValid = 0, rReady = 0, awRdy, wRdy, bValid, arRdy, rValid;
   logic [7:0] awAddr = 0, arAddr = 0, tunData;
   logic [31:0] wData = 0, rData, sec, ns;
   logic [1:0] bResp, rResp;
   logic tunValid, tunReady, tunFirst, tunLast;
   int sets;
   logic [8:0] exq[$];
   int fails = 0, checks = 0, pkts = 0, pos = 0, cyc = 0, seed = 98414;
   tm_packetizer #(.FRAME_CYC(60)) i_tm_packetizer (.sys_clk(sys_clk),
      .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wValid), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arRdy), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .tunData(tunData), .tunValid(tunValid), .tunReady(tunReady),
      .tunFirst(tunFirst), .tunLast(tunLast));
   tm_sink i_tm_sink (.sys_clk(sys_clk), .reset(reset), .tunData(tunData),
      .tunValid(tunValid), .tunFirst(tunFirst), .tunReady(tunReady),
      .sets(sets));
   initial forever #50 sys_clk = ~sys_clk;
   task automatic test_done;
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         test_done;
      end
   end
   // ==========================================================
   // Bus tasks, entered just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      logic [1:0] r;
      aw = 1;
      w = 1;
      awAddr <= a;
      wData <= d;
      awValid <= 1;
      wValid <= 1;
      bReady <= 1;
      while (aw || w)
      begin
         @(negedge sys_clk);
         aw = aw && !awRdy;
         w = w && !wRdy;
         @(posedge sys_clk);
         if (!aw)
            awValid <= 0;
         if (!w)
            wValid <= 0;
      end
      do
      begin
         @(negedge sys_clk);
         aw = bValid;
         r = bResp;
         @(posedge sys_clk);
      end
      while (!aw);
      `CHK(r, 2'b00)
      bReady <= 0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      arAddr <= a;
      arValid <= 1;
      rReady <= 1;
      do
         @(negedge sys_clk);
      while (!arRdy);
      @(posedge sys_clk);
      arValid <= 0;
      do
         @(negedge sys_clk);
      while (!rValid);
      `CHK(rData, d)
      `CHK(rResp, r)
      @(posedge sys_clk);
      rReady <= 0;
      @(posedge sys_clk);
   endtask
   // ==========================================================
   // Expected header bytes of one packet, with care mask
   task automatic note(input int p, input logic [15:0] s,
                       input logic [31:0] t);
      logic [351:0] hb;
      logic [43:0] m;
      hb = {8'h45, 8'h00, 16'h0, s, 16'h0, RST_NET[31:24], IP_PROTO_UDP,
         16'h0, RST_SRCIP, DST_IP, RST_NET[15:0], DST_PORT, 32'h0, 8'h80,
         1'(p == 0), RTP_PT, s, t, 32'h0, 16'h001a, 8'h00, RST_CFG0[3:0],
         RST_CFG0[7:4]};
      m = {2'b11, 2'b00, 6'h3f, 2'b00, 12'hfff, 4'b0011, 12'hfff, {4{p == 0}}};
      for (int i = 43; i >= 0; i--)
         exq.push_back({m[i], hb[i*8 +: 8]});
   endtask
   // Header and structure start of every taken byte
   always @(negedge sys_clk)
      if (!reset && tunValid && tunReady)
      begin
         pos = tunFirst ? 0 : pos + 1;
         if (pos < 44)
         begin
            logic [8:0] e;
            e = exq.pop_front();
            if (e[8])
               `CHK(tunData, e[7:0])
         end
         if (tunLast)
            pkts++;
      end
   // ==========================================================
   // Main sequence: two split sets, late flag, unmapped read
   initial
   begin
      repeat (5) @(posedge sys_clk);
      reset <= 0;
      @(posedge sys_clk);
      wr(REG_SEG, 32'h00040009);
      wr(REG_BUF, $random(seed));
      for (int k = 0; k < 2; k++)
      begin
         sec = $random(seed);
         ns = {$random(seed)} % 32'd1000000000;
         wr(REG_SEC, sec);
         wr(REG_NS, ns);
         for (int p = 0; p < 3; p++)
            note(p, 16'(3 * k + p), {sec[21:0], ns[29:20]});
         wr(REG_CTRL, 32'h00000001);
         while (pkts < 3 * k + 3) @(posedge sys_clk);
         rd(REG_STAT, {16'(3 * k + 3), 16'h0002}, 2'b00);
         wr(REG_CTRL, 32'h00000002);
         rd(REG_STAT, {16'(3 * k + 3), 16'h0000}, 2'b00);
      end
      rd(8'h3c, 32'h0, 2'b10);
      `CHK(exq.size(), 0)
      `CHK(sets, 2)
      test_done;
   end
endmodule // timing_mgmt_rtp_packetizer_tb
